// File: sdo_pkg.sv
package sdo_pkg;

	// ----------------------------------------------------------------
	// frame layout and identifiers
	// ----------------------------------------------------------------
	localparam logic [10:0] ID_RX_BASE  = 11'h600;
	localparam logic [10:0] ID_TX_BASE  = 11'h580;
	localparam logic [3:0]  FRAME_DLC   = 4'h8;
	localparam logic [6:0]  STATION_MIN = 7'h01;
	localparam logic [6:0]  STATION_MAX = 7'h7F;

	// ----------------------------------------------------------------
	// command specifiers
	// ----------------------------------------------------------------
	localparam logic [2:0] CCS_DL_SEG  = 3'h0;
	localparam logic [2:0] CCS_DL_INIT = 3'h1;
	localparam logic [2:0] CCS_UL_INIT = 3'h2;
	localparam logic [2:0] CCS_UL_SEG  = 3'h3;
	localparam logic [2:0] CCS_ABORT   = 3'h4;
	localparam logic [7:0] SPEC_UL_1   = 8'h4F;
	localparam logic [7:0] SPEC_UL_2   = 8'h4B;
	localparam logic [7:0] SPEC_UL_3   = 8'h47;
	localparam logic [7:0] SPEC_UL_4   = 8'h43;
	localparam logic [7:0] SPEC_DL_OK  = 8'h60;
	localparam logic [7:0] SPEC_SEG_OK = 8'h20;
	localparam logic [7:0] SPEC_ABORT  = 8'h80;
	localparam int         TOGGLE_POS  = 4;
	localparam logic [2:0] EXP_BYTES   = 3'h4;
	localparam logic [2:0] SEG_BYTES   = 3'h7;

	// ----------------------------------------------------------------
	// abort codes
	// ----------------------------------------------------------------
	localparam logic [31:0] AB_INVALID    = 32'h05040001;
	localparam logic [31:0] AB_WRITE_ONLY = 32'h06010001;
	localparam logic [31:0] AB_READ_ONLY  = 32'h06010002;
	localparam logic [31:0] AB_NO_INDEX   = 32'h06020000;
	localparam logic [31:0] AB_NO_MAP     = 32'h06040041;
	localparam logic [31:0] AB_FAULT      = 32'h06060000;
	localparam logic [31:0] AB_LEN        = 32'h06070010;
	localparam logic [31:0] AB_LEN_HIGH   = 32'h06070012;
	localparam logic [31:0] AB_LEN_LOW    = 32'h06070013;
	localparam logic [31:0] AB_NO_SUB     = 32'h06090011;
	localparam logic [31:0] AB_RANGE      = 32'h06090030;
	localparam logic [31:0] AB_RANGE_HIGH = 32'h06090031;
	localparam logic [31:0] AB_RANGE_LOW  = 32'h06090032;
	localparam logic [31:0] AB_STATE      = 32'h08000022;
	localparam logic [1:0]  ERR_NONE      = 2'h0;
	localparam logic [1:0]  ERR_ANY       = 2'h1;
	localparam logic [1:0]  ERR_HIGH      = 2'h2;

	// ----------------------------------------------------------------
	// register map and log memory
	// ----------------------------------------------------------------
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LAST   = 8'h08;
	localparam logic [7:0] OFF_COUNT  = 8'h0C;
	localparam logic [7:0] OFF_LOG    = 8'h20;
	localparam logic [7:0] CTRL_RST   = 8'h81;
	localparam int         LOG_AW     = 3;
	localparam int         LOG_W      = 32;

	typedef struct packed {
		logic [10:0] id;
		logic [3:0]  dlc;
		logic [63:0] data;
	} can_frame_s;

	typedef struct packed {
		logic        write;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [2:0]  len;
		logic [31:0] wdata;
	} od_req_s;

	typedef struct packed {
		logic        idx_ok;
		logic        sub_ok;
		logic        rd_ok;
		logic        wr_ok;
		logic        map_bad;
		logic        fault_blk;
		logic        state_blk;
		logic [1:0]  len_err;
		logic [1:0]  range_err;
		logic [2:0]  len;
		logic [31:0] rdata;
	} od_resp_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DECODE = 2'b01,
		ST_OD     = 2'b11,
		ST_REPLY  = 2'b10
	} state_e;

endpackage

// File: abort_log_mem.sv
module abort_log_mem (
	input  wire logic              pclk,    // system clock
	input  wire logic              presetn, // async reset, low
	input  wire logic              we,      // write strobe
	input  wire logic [sdo_pkg::LOG_AW-1:0] waddr, // write slot
	input  wire logic [sdo_pkg::LOG_W-1:0]  wdata, // code to store
	input  wire logic [sdo_pkg::LOG_AW-1:0] raddr, // read slot
	output logic      [sdo_pkg::LOG_W-1:0]  rdata  // registered read
);
	import sdo_pkg::*;

	logic [LOG_W-1:0] mem [2**LOG_AW];

	// ----------------------------------------------------------------
	// storage, no reset so it maps onto plain ram
	// ----------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read data one cycle after the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// File: sdo_expedited_server.sv
// How it works
// - station number must be 1 to 127; otherwise server stays silent
// - exactly one reply frame for each service request taken; the code sends none for an abort request
// - download is an entry write, upload is an entry read
// - five protocols: initiate/segment download, initiate/segment upload, abort
// - segment toggle bit must alternate, starting cleared
// - irrelevant specifier bits must be zero, else invalid command
// - expedited flag set carries data directly in bytes 4-7
// - size flag marks length given; expedited and size both clear is reserved
// - unused byte count only meaningful with expedited and size set
// - normal transfer with size carries byte count, byte 4 least significant
// - read answer specifier 0x4F, 0x4B or 0x43 by data size; the code also answers 0x47 for 3 bytes
// - unserved read answered with abort specifier 0x80
// - accepted write answered 0x60 with index and subindex echoed; the code answers an accepted segment 0x20 with toggle, index and subindex zero
// - rejected write answered 0x80 with a 32-bit cause code
// - unknown or illegal specifier aborts with 0x05040001
// - read of write-only 0x06010001, write of read-only 0x06010002
// - missing index 0x06020000, missing subindex 0x06090011
// - entry that cannot be mapped aborts 0x06040041
// - access failing due to drive fault aborts 0x06060000
// - length mismatch 0x06070010, too long 0x06070012, too short 0x06070013
// - out of range 0x06090030, too large 0x06090031, too small 0x06090032
// - refused by device state aborts 0x08000022
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module sdo_expedited_server (
	input  wire logic                     pclk,         // system clock
	input  wire logic                     presetn,      // async reset, low
	input  wire logic [sdo_pkg::ADDR_W-1:0] paddr,      // apb address
	input  wire logic                     psel,         // apb select
	input  wire logic                     penable,      // apb enable
	input  wire logic                     pwrite,       // apb direction
	input  wire logic [31:0]              pwdata,       // apb write data
	output logic      [31:0]              prdata,       // apb read data
	output logic                          pready,       // apb ready
	output logic                          pslverr,      // apb error
	input  wire logic                     rx_valid,     // frame offered
	output logic                          rx_ready,     // frame taken
	input  wire sdo_pkg::can_frame_s      rx_frame,     // received frame
	output logic                          tx_valid,     // reply offered
	input  wire logic                     tx_ready,     // reply taken
	output sdo_pkg::can_frame_s           tx_frame,     // reply frame
	output logic                          od_req_valid, // dictionary access
	output sdo_pkg::od_req_s              od_req,       // access details
	input  wire logic                     od_ack,       // access done
	input  wire sdo_pkg::od_resp_s        od_resp       // access result
);
	import sdo_pkg::*;

	state_e      state_reg;
	state_e      state_next;
	can_frame_s  rq_reg;
	logic [7:0]  ctrl_reg;
	logic        seg_open_reg;
	logic        toggle_reg;
	logic        is_seg_reg;
	logic [2:0]  seg_len_reg;
	logic [15:0] seg_idx_reg;
	logic [7:0]  seg_sub_reg;
	logic [31:0] last_abort_reg;
	logic [15:0] req_cnt_reg;
	logic [15:0] abort_cnt_reg;
	logic [LOG_AW-1:0] log_ptr_reg;
	logic        apb_wait_reg;
	logic [31:0] log_rdata;
	logic [7:0]  spec;
	logic [2:0]  ccs;
	logic [15:0] echo_idx;
	logic [7:0]  echo_sub;
	logic        rx_take;
	logic        station_ok;
	logic        dec_od;
	logic        dec_silent;
	logic        dec_abort;
	logic        dec_open;
	logic [31:0] dec_code;
	od_req_s     od_n;
	logic        od_bad;
	logic [31:0] od_code;
	logic        abort_evt;
	logic [31:0] ev_code;
	logic        apb_acc;
	logic        addr_ok;
	logic [31:0] reg_val;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic station_valid(input logic [6:0] s);
		return (s >= STATION_MIN) && (s <= STATION_MAX);
	endfunction

	// byte 0 specifier, bytes 1-2 index low first, 3 sub, 4-7 data
	function automatic logic [63:0] pack_reply(input logic [7:0] sp,
		input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] d);
		return {d, sb, idx, sp};
	endfunction

	function automatic logic [7:0] read_spec(input logic [2:0] len);
		unique case (len)
			3'h1:    return SPEC_UL_1;
			3'h2:    return SPEC_UL_2;
			3'h3:    return SPEC_UL_3;
			default: return SPEC_UL_4;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// frame intake
	// ----------------------------------------------------------------
	// foreign frames are consumed and dropped in idle, so they stall the bus only while a request is being served
	assign station_ok = station_valid(ctrl_reg[6:0]);
	assign rx_ready   = (state_reg == ST_IDLE);
	assign rx_take    = rx_valid && rx_ready && ctrl_reg[7] && station_ok &&
		(rx_frame.id == ID_RX_BASE + {4'h0, ctrl_reg[6:0]}) &&
		(rx_frame.dlc == FRAME_DLC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rq_reg <= '0;
		end else if (rx_take) begin
			rq_reg <= rx_frame;
		end
	end

	assign spec     = rq_reg.data[7:0];
	assign ccs      = spec[7:5];
	assign echo_idx = (ccs == CCS_DL_SEG) ? seg_idx_reg : rq_reg.data[23:8];
	assign echo_sub = (ccs == CCS_DL_SEG) ? seg_sub_reg : rq_reg.data[31:24];

	// ----------------------------------------------------------------
	// specifier decode
	// ----------------------------------------------------------------
	always_comb begin
		dec_od     = 1'b0;
		dec_silent = 1'b0;
		dec_abort  = 1'b1;
		dec_open   = 1'b0;
		dec_code   = AB_INVALID;
		od_n       = '0;
		od_n.index = rq_reg.data[23:8];
		od_n.sub   = rq_reg.data[31:24];
		unique case (ccs)
			CCS_UL_INIT: begin
				if (spec[4:0] == 5'h00) begin
					dec_abort = 1'b0;
					dec_od    = 1'b1;
				end
			end
			CCS_DL_INIT: begin
				// reserved e=0,s=0 and stray unused count fall to abort
				if (!spec[4] && (spec[1] || spec[0]) &&
					((spec[1] && spec[0]) || spec[3:2] == 2'h0)) begin
					if (spec[1]) begin
						dec_abort  = 1'b0;
						dec_od     = 1'b1;
						od_n.write = 1'b1;
						od_n.wdata = rq_reg.data[63:32];
						od_n.len   = spec[0] ? EXP_BYTES - {1'b0, spec[3:2]}
							: EXP_BYTES;
					end else if (rq_reg.data[63:32] > 32'h00000004) begin
						dec_code = AB_LEN_HIGH;
					end else if (rq_reg.data[63:32] == 32'h00000000) begin
						dec_code = AB_LEN_LOW;
					end else begin
						dec_abort = 1'b0;
						dec_open  = 1'b1;
					end
				end
			end
			CCS_DL_SEG: begin
				if (seg_open_reg && spec[TOGGLE_POS] == toggle_reg) begin
					if (SEG_BYTES - spec[3:1] > seg_len_reg) begin
						dec_code = AB_LEN_HIGH;
					end else if (SEG_BYTES - spec[3:1] < seg_len_reg) begin
						dec_code = AB_LEN_LOW;
					end else begin
						dec_abort  = 1'b0;
						dec_od     = 1'b1;
						od_n.write = 1'b1;
						od_n.index = seg_idx_reg;
						od_n.sub   = seg_sub_reg;
						od_n.len   = seg_len_reg;
						od_n.wdata = rq_reg.data[39:8];
					end
				end
			end
			CCS_ABORT: begin
				dec_abort  = 1'b0;
				dec_silent = 1'b1;
			end
			CCS_UL_SEG: begin
				dec_code = AB_INVALID; // no upload is ever left open
			end
			default: begin
				dec_code = AB_INVALID;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// dictionary result to abort code, first failing check wins
	// ----------------------------------------------------------------
	always_comb begin
		od_code = '0;
		if (!od_resp.idx_ok) begin
			od_code = AB_NO_INDEX;
		end else if (!od_resp.sub_ok) begin
			od_code = AB_NO_SUB;
		end else if (od_req.write && !od_resp.wr_ok) begin
			od_code = AB_READ_ONLY;
		end else if (!od_req.write && !od_resp.rd_ok) begin
			od_code = AB_WRITE_ONLY;
		end else if (od_resp.map_bad) begin
			od_code = AB_NO_MAP;
		end else if (od_resp.fault_blk) begin
			od_code = AB_FAULT;
		end else if (od_resp.state_blk) begin
			od_code = AB_STATE;
		end else if (od_req.write && od_resp.len_err != ERR_NONE) begin
			od_code = (od_resp.len_err == ERR_ANY) ? AB_LEN :
				(od_resp.len_err == ERR_HIGH) ? AB_LEN_HIGH : AB_LEN_LOW;
		end else if (od_req.write && od_resp.range_err != ERR_NONE) begin
			od_code = (od_resp.range_err == ERR_ANY) ? AB_RANGE :
				(od_resp.range_err == ERR_HIGH) ? AB_RANGE_HIGH : AB_RANGE_LOW;
		end
	end

	assign od_bad    = (od_code != 32'h00000000);
	assign abort_evt = (state_reg == ST_DECODE && !dec_od && dec_abort) ||
		(state_reg == ST_OD && od_ack && od_bad);
	assign ev_code   = (state_reg == ST_DECODE) ? dec_code : od_code;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (rx_take) begin
					state_next = ST_DECODE;
				end
			end
			ST_DECODE: begin
				state_next = dec_silent ? ST_IDLE : dec_od ? ST_OD : ST_REPLY;
			end
			ST_OD: begin
				if (od_ack) begin
					state_next = ST_REPLY;
				end
			end
			ST_REPLY: begin
				if (tx_ready) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// request held steady for the whole dictionary handshake
	assign od_req_valid = (state_reg == ST_OD);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			od_req <= '0;
		end else if (state_reg == ST_DECODE) begin
			od_req <= od_n;
		end
	end

	// ----------------------------------------------------------------
	// segmented download bookkeeping
	// ----------------------------------------------------------------
	// every decoded request closes an open download unless it reopens one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_open_reg <= 1'b0;
			toggle_reg   <= 1'b0;
			is_seg_reg   <= 1'b0;
			seg_len_reg  <= '0;
			seg_idx_reg  <= '0;
			seg_sub_reg  <= '0;
		end else if (state_reg == ST_DECODE) begin
			seg_open_reg <= dec_open;
			is_seg_reg   <= (ccs == CCS_DL_SEG);
			if (dec_open) begin
				toggle_reg  <= 1'b0;
				seg_len_reg <= rq_reg.data[34:32];
				seg_idx_reg <= rq_reg.data[23:8];
				seg_sub_reg <= rq_reg.data[31:24];
			end else if (ccs == CCS_DL_SEG && dec_od) begin
				toggle_reg <= ~toggle_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// reply frame
	// ----------------------------------------------------------------
	assign tx_valid = (state_reg == ST_REPLY);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_frame <= '0;
		end else begin
			tx_frame.id  <= ID_TX_BASE + {4'h0, ctrl_reg[6:0]};
			tx_frame.dlc <= FRAME_DLC;
			if (state_reg == ST_DECODE && !dec_od) begin
				tx_frame.data <= dec_abort ?
					pack_reply(SPEC_ABORT, echo_idx, echo_sub, dec_code) :
					pack_reply(SPEC_DL_OK, echo_idx, echo_sub, 32'h00000000);
			end else if (state_reg == ST_OD && od_ack) begin
				if (od_bad) begin
					tx_frame.data <= pack_reply(SPEC_ABORT, od_req.index,
						od_req.sub, od_code);
				end else if (od_req.write && is_seg_reg) begin
					tx_frame.data <= pack_reply(SPEC_SEG_OK | {3'h0, ~toggle_reg, 4'h0},
						16'h0000, 8'h00, 32'h00000000);
				end else if (od_req.write) begin
					tx_frame.data <= pack_reply(SPEC_DL_OK, od_req.index,
						od_req.sub, 32'h00000000);
				end else begin
					tx_frame.data <= pack_reply(read_spec(od_resp.len),
						od_req.index, od_req.sub, od_resp.rdata);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// statistics and abort log
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_cnt_reg    <= '0;
			abort_cnt_reg  <= '0;
			last_abort_reg <= '0;
			log_ptr_reg    <= '0;
		end else begin
			if (rx_take) begin
				req_cnt_reg <= req_cnt_reg + 16'h0001;
			end
			if (abort_evt) begin
				abort_cnt_reg  <= abort_cnt_reg + 16'h0001;
				last_abort_reg <= ev_code;
				log_ptr_reg    <= log_ptr_reg + LOG_AW'(1);
			end
		end
	end

	abort_log_mem u_log (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (abort_evt),
		.waddr   (log_ptr_reg),
		.wdata   (ev_code),
		.raddr   (paddr[LOG_AW+1:2]),
		.rdata   (log_rdata)
	);

	// ----------------------------------------------------------------
	// apb slave, fixed one wait state so log reads can be registered
	// ----------------------------------------------------------------
	assign apb_acc = psel && penable;
	assign pready  = apb_acc && apb_wait_reg;
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFF_COUNT ||
		(paddr[7:5] == OFF_LOG[7:5]));
	assign pslverr = pready && !addr_ok;

	always_comb begin
		reg_val = 32'h00000000;
		unique case (paddr)
			OFF_CTRL:   reg_val = {24'h000000, ctrl_reg};
			OFF_STATUS: reg_val = {26'h0, station_ok, is_seg_reg, toggle_reg,
				seg_open_reg, state_reg};
			OFF_LAST:   reg_val = last_abort_reg;
			OFF_COUNT:  reg_val = {abort_cnt_reg, req_cnt_reg};
			default:    reg_val = (paddr[7:5] == OFF_LOG[7:5]) ? log_rdata
				: 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_wait_reg <= 1'b0;
			prdata       <= '0;
			ctrl_reg     <= CTRL_RST;
		end else begin
			apb_wait_reg <= apb_acc && !apb_wait_reg;
			if (apb_acc && !apb_wait_reg) begin
				prdata <= addr_ok ? reg_val : 32'h00000000;
			end
			if (pready && pwrite && paddr == OFF_CTRL) begin
				ctrl_reg <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_reply_id;
		@(posedge pclk) disable iff (!presetn)
		tx_valid |-> tx_frame.id == ID_TX_BASE + {4'h0, ctrl_reg[6:0]} &&
			tx_frame.dlc == FRAME_DLC;
	endproperty
	a_reply_id: assert property (p_reply_id) else $error("bad reply id");

	property p_station;
		@(posedge pclk) disable iff (!presetn)
		rx_take |-> ctrl_reg[6:0] != 7'h00;
	endproperty
	a_station: assert property (p_station) else $error("bad station");

	property p_reply_held;
		@(posedge pclk) disable iff (!presetn)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
	endproperty
	a_reply_held: assert property (p_reply_held) else $error("reply lost");

	property p_one_reply;
		@(posedge pclk) disable iff (!presetn)
		tx_valid && tx_ready |=> !tx_valid ##1 !tx_valid;
	endproperty
	a_one_reply: assert property (p_one_reply) else $error("extra reply");

	property p_read_spec;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_OD && od_ack && !od_bad && !od_req.write &&
			od_resp.len == 3'h2 |=> tx_frame.data[7:0] == SPEC_UL_2;
	endproperty
	a_read_spec: assert property (p_read_spec) else $error("read spec");

	property p_write_ok;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_OD && od_ack && !od_bad && od_req.write && !is_seg_reg
			|=> tx_frame.data[31:0] == {$past(od_req.sub), $past(od_req.index),
			SPEC_DL_OK};
	endproperty
	a_write_ok: assert property (p_write_ok) else $error("write echo");

	property p_abort_code;
		@(posedge pclk) disable iff (!presetn)
		abort_evt |=> tx_frame.data[7:0] == SPEC_ABORT &&
			tx_frame.data[63:32] == $past(ev_code) && tx_valid;
	endproperty
	a_abort_code: assert property (p_abort_code) else $error("abort reply");

	property p_illegal;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_DECODE && ccs > CCS_ABORT |=>
			tx_frame.data[63:32] == AB_INVALID && tx_valid;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal spec");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_DECODE && ccs == CCS_DL_INIT && spec[1:0] == 2'h0
			|=> state_reg == ST_REPLY && tx_frame.data[63:32] == AB_INVALID;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved e s");

	property p_no_index;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_OD && od_ack && !od_resp.idx_ok |=>
			tx_frame.data[63:32] == AB_NO_INDEX;
	endproperty
	a_no_index: assert property (p_no_index) else $error("index code");
endmodule

// File: od_partner.sv
module od_partner (
	input  wire logic             pclk,         // system clock
	input  wire logic             presetn,      // async reset, low
	input  wire logic             slow,         // late answers
	input  wire logic             od_req_valid, // access pending
	input  wire sdo_pkg::od_req_s od_req,       // access details
	output logic                  od_ack,       // access done
	output sdo_pkg::od_resp_s     od_resp       // access result
);
	import sdo_pkg::*;
	logic [2:0] el;
	logic [1:0] wait_reg;
	// entries 6040/6060/6081 rw, 6041 ro, 607A wo; sizes 2, 1 or 4 bytes
	always_comb begin
		el = (od_req.index[7:4] == 4'h6) ? 3'h1 : (od_req.index[7:4] > 4'h6) ? 3'h4 : 3'h2;
		od_resp = '0;
		od_resp.idx_ok = od_req.index inside {16'h6040, 16'h6041, 16'h6060, 16'h607A, 16'h6081};
		od_resp.sub_ok = (od_req.sub == 8'h00);
		od_resp.rd_ok = (od_req.index != 16'h607A);
		od_resp.wr_ok = (od_req.index != 16'h6041);
		od_resp.len = el;
		od_resp.rdata = 32'hFFFFC031;
		if (od_req.write && od_req.len != el)
			od_resp.len_err = (od_req.len > el) ? ERR_HIGH : 2'h3;
		od_ack = od_req_valid && (wait_reg == (slow ? 2'h3 : 2'h0));
	end
	// wait count; cleared between accesses so each answer is one pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_reg <= 2'h0;
		else
			wait_reg <= od_req_valid ? wait_reg + 2'h1 : 2'h0;
	end
endmodule

// File: tb_sdo_expedited_server.sv
module tb_sdo_expedited_server;
	timeunit 1ns;
	timeprecision 1ns;
	import sdo_pkg::*;
	localparam logic [31:0] RDV = 32'hFFFFC031;
	logic       pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic       rx_valid = 1'b0, tx_ready = 1'b0, slow = 1'b0, er;
	logic       pready, pslverr, rx_ready, tx_valid, od_req_valid, od_ack;
	logic [7:0] paddr = 8'h00;
	logic [10:0] rid = 11'h601, tid = 11'h581;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	can_frame_s rx_frame = '0, tx_frame;
	od_req_s    od_req;
	od_resp_s   od_resp;
	int         err_count = 0, n_tests = 0;

	sdo_expedited_server u_sdo_expedited_server (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_ready, .rx_frame,
		.tx_valid, .tx_ready, .tx_frame, .od_req_valid, .od_req, .od_ack, .od_resp);
	od_partner u_od_partner (.pclk, .presetn, .slow, .od_req_valid, .od_req, .od_ack, .od_resp);

	// 20 MHz system clock
	always #25 pclk = ~pclk;

	task automatic chk(input logic [78:0] got, input logic [78:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// a used-up wait counts as a mismatch and ends the run
	task automatic hang(input int i);
		if (i >= 40) begin
			err_count++;
			test_done();
		end
	endtask

	// apb transfer; request held until pready, idle edge first
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++i < 40);
		hang(i);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one request frame; a zero specifier means no reply may come
	task automatic xfer(input logic [7:0] sp, input logic [15:0] ix, input logic [31:0] d,
			input logic [7:0] esp, input logic [31:0] ed);
		int i;
		can_frame_s exp;
		i = 0;
		@(posedge pclk);
		rx_frame <= {rid, FRAME_DLC, d, 8'h00, ix, sp};
		rx_valid <= 1'b1;
		do @(posedge pclk); while (rx_ready !== 1'b1 && ++i < 40);
		hang(i);
		rx_valid <= 1'b0;
		i = 0;
		do @(posedge pclk); while (tx_valid !== 1'b1 && ++i < 40);
		if (esp == 8'h00) begin
			chk(tx_valid, 1'b0);
		end else begin
			hang(i);
			exp = {tid, FRAME_DLC, ed, 8'h00, ix, esp};
			chk(tx_frame, exp);
			tx_ready <= 1'b1;
			@(posedge pclk);
			tx_ready <= 1'b0;
		end
	endtask

	task automatic t_regs();
		apb(1'b0, OFF_CTRL, 32'h0);
		chk({rd, er}, {32'h81, 1'b0});
		apb(1'b0, 8'h10, 32'h0);
		chk({rd, er}, {32'h0, 1'b1});
		apb(1'b1, OFF_CTRL, 32'h85);
		xfer(8'h40, 16'h6041, 32'h0, 8'h00, 32'h0);
		rid = 11'h605;
		tid = 11'h585;
		xfer(8'h40, 16'h6041, 32'h0, SPEC_UL_2, RDV);
		apb(1'b1, OFF_CTRL, 32'h80);
		rid = 11'h600;
		xfer(8'h40, 16'h6041, 32'h0, 8'h00, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h81);
		rid = 11'h601;
		tid = 11'h581;
		$display("t_regs done");
	endtask

	task automatic t_read();
		slow <= 1'b1;
		xfer(8'h40, 16'h6041, 32'h0, SPEC_UL_2, RDV);
		xfer(8'h40, 16'h6060, 32'h0, SPEC_UL_1, RDV);
		xfer(8'h40, 16'h6081, 32'h0, SPEC_UL_4, RDV);
		xfer(8'h40, 16'h607A, 32'h0, SPEC_ABORT, AB_WRITE_ONLY);
		xfer(8'h40, 16'h1234, 32'h0, SPEC_ABORT, AB_NO_INDEX);
		slow <= 1'b0;
		$display("t_read done");
	endtask

	task automatic t_write();
		xfer(8'h2B, 16'h6040, 32'h000F, SPEC_DL_OK, 32'h0);
		xfer(8'h2F, 16'h6060, 32'h0006, SPEC_DL_OK, 32'h0);
		xfer(8'h23, 16'h6081, 32'h00369D03, SPEC_DL_OK, 32'h0);
		xfer(8'h2B, 16'h6041, 32'h1, SPEC_ABORT, AB_READ_ONLY);
		xfer(8'h23, 16'h6040, 32'h1, SPEC_ABORT, AB_LEN_HIGH);
		xfer(8'h2F, 16'h6040, 32'h1, SPEC_ABORT, AB_LEN_LOW);
		$display("t_write done");
	endtask

	task automatic t_bad();
		xfer(8'hE0, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h20, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h2D, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h50, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h60, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h80, 16'h6040, 32'h0, 8'h00, 32'h0);
		$display("t_bad done");
	endtask

	// one-segment download: open, segment, toggle and length faults
	task automatic t_seg();
		xfer(8'h21, 16'h6040, 32'h2, SPEC_DL_OK, 32'h0);
		xfer(8'h0A, 16'h0000, 32'h0, SPEC_SEG_OK, 32'h0);
		xfer(8'h0A, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h21, 16'h6040, 32'h2, SPEC_DL_OK, 32'h0);
		xfer(8'h1A, 16'h6040, 32'h0, SPEC_ABORT, AB_INVALID);
		xfer(8'h21, 16'h6040, 32'h2, SPEC_DL_OK, 32'h0);
		xfer(8'h08, 16'h6040, 32'h0, SPEC_ABORT, AB_LEN_HIGH);
		xfer(8'h21, 16'h6040, 32'h5, SPEC_ABORT, AB_LEN_HIGH);
		xfer(8'h21, 16'h6040, 32'h0, SPEC_ABORT, AB_LEN_LOW);
		apb(1'b0, OFF_LAST, 32'h0);
		chk({rd, er}, {AB_LEN_LOW, 1'b0});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk({rd, er}, {32'h20, 1'b0});
		$display("t_seg done");
	endtask

	// reset for four cycles, then every scenario in turn
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_read();
		t_write();
		t_bad();
		t_seg();
		test_done();
	end
endmodule
